//--- bench/cdio_monitor.sv
// Port-level assertions for the camera digital I/O block
`default_nettype none
module cdio_monitor
	import cdio_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Watched ports
	input wire logic TRIGGER_INPUT_PIN,
	input wire logic TRIGGER_CLEAN,
	input wire logic [cdio_pkg::GLITCH_W-1:0] GLITCH_FILTER_TIME,
	input wire logic [cdio_pkg::NUM_OUT-1:0] OUTPUT_PINS_OE,
	input wire logic CFG_WRITE,
	input wire logic [cdio_pkg::SEL_W-1:0] PIN_SELECT,
	input wire logic PIN_DIRECTION,
	input wire logic EXPOSURE_START,
	input wire logic EXPOSURE_END,
	input wire logic EXPOSURE_FLAG,
	input wire logic EVENT_TYPE_SELECT,
	input wire logic EVENT_MESSAGE_ENABLE,
	input wire logic TEST_EVENT_FIRE,
	input wire logic EVENT_VALID,
	input wire logic EVENT_READY
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	property p_dir; PIN_DIRECTION == (PIN_SELECT != PIN_TRIGGER); endproperty
	a_dir: assert property (p_dir) else $error("direction wrong");
	property p_oe; $changed(OUTPUT_PINS_OE) |-> $past(CFG_WRITE, 2); endproperty
	a_oe: assert property (p_oe) else $error("enable moved alone");
	property p_xon; EXPOSURE_START |=> EXPOSURE_FLAG; endproperty
	a_xon: assert property (p_xon) else $error("exposure not raised");
	property p_xoff; EXPOSURE_END && !EXPOSURE_START |=> !EXPOSURE_FLAG; endproperty
	a_xoff: assert property (p_xoff) else $error("exposure not lowered");
	property p_xhold; !EXPOSURE_START && !EXPOSURE_END |=> $stable(EXPOSURE_FLAG); endproperty
	a_xhold: assert property (p_xhold) else $error("exposure moved");
	// Raw level must have stood well before a filtered change is committed
	property p_filt; $changed(TRIGGER_CLEAN) && GLITCH_FILTER_TIME != 0 |->
		$past(TRIGGER_INPUT_PIN, 5) == TRIGGER_CLEAN && $past(TRIGGER_INPUT_PIN, 40) == TRIGGER_CLEAN;
	endproperty
	a_filt: assert property (p_filt) else $error("short pulse passed");
	property p_evon; !EVENT_VALID && TEST_EVENT_FIRE && EVENT_MESSAGE_ENABLE &&
		EVENT_TYPE_SELECT == EVT_TEST |-> ##[1:400] EVENT_VALID; endproperty
	a_evon: assert property (p_evon) else $error("no message");
	property p_evhold; EVENT_VALID && !EVENT_READY |=> EVENT_VALID; endproperty
	a_evhold: assert property (p_evhold) else $error("message dropped");
	property p_evdone; EVENT_VALID && EVENT_READY |=> !EVENT_VALID; endproperty
	a_evdone: assert property (p_evdone) else $error("message repeated");
	c_taken: cover property (EVENT_VALID && EVENT_READY);
	c_clean: cover property ($rose(TRIGGER_CLEAN));
	c_expo: cover property ($fell(EXPOSURE_FLAG));
endmodule
bind cdio_top cdio_monitor u_mon (.*);
`default_nettype wire

//--- bench/cdio_partner.sv
// Far side: trigger source and a host that takes event messages
`default_nettype none
module cdio_partner (
	// Host side
	input wire logic clk,
	input wire logic valid,
	input wire logic [3:0] lat,
	output logic ready,
	// Trigger source
	output logic trig
);
	timeunit 1ns;
	timeprecision 1ps;
	int n = 0;
	initial ready = 1'h0;
	initial trig = 1'h0;
	// Slow host: takes a message only after lat cycles
	always @(posedge clk) begin
		n <= (valid && !ready) ? n + 1 : 0;
		ready <= valid && !ready && n >= int'(lat);
	end
	task automatic drive(input logic lvl, input int cyc);
		@(posedge clk);
		trig <= lvl;
		repeat (cyc) @(posedge clk);
		#1;
	endtask
endmodule
`default_nettype wire

//--- bench/cdio_tb_top.sv
// Self-checking bench for the camera digital I/O block
`default_nettype none
module cdio_tb_top;
	import cdio_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK, RST, TRIGGER_INPUT_PIN, FRAME_READOUT_FLAG, ROW_TIME_FLAG, EXPOSURE_START;
	logic EXPOSURE_END, TIMER_PULSE_SOURCE, COUNTER_PULSE_SOURCE, CFG_WRITE, OUTPUT_INVERT;
	logic USER_LEVEL_VALUE, PIN_DIRECTION, EXPOSURE_FLAG, TRIGGER_CLEAN, EVENT_TYPE_SELECT;
	logic EVENT_MESSAGE_ENABLE, TEST_EVENT_FIRE, EVENT_VALID, EVENT_READY;
	logic [NUM_OUT-1:0] OUTPUT_PINS, OUTPUT_PINS_OE;
	logic [SEL_W-1:0] PIN_SELECT;
	logic [SRC_W-1:0] OUTPUT_SOURCE_SELECT;
	logic [GLITCH_W-1:0] GLITCH_FILTER_TIME;
	logic [15:0] TEST_ACK_WAIT, EVENT_ID;
	logic [3:0] lat;
	int n_fail = 0;
	int checks_done = 0;
	cdio_top u_dut (.*);
	cdio_partner u_far (.clk(CLK), .valid(EVENT_VALID), .lat(lat), .ready(EVENT_READY),
		.trig(TRIGGER_INPUT_PIN));
	initial begin
		CLK = 1'h0;
		forever #10 CLK = ~CLK;
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask
	task automatic cfg(input logic [2:0] sel, input logic [2:0] src, input logic inv);
		@(posedge CLK);
		PIN_SELECT <= sel;
		OUTPUT_SOURCE_SELECT <= src;
		OUTPUT_INVERT <= inv;
		CFG_WRITE <= 1'h1;
		@(posedge CLK);
		CFG_WRITE <= 1'h0;
	endtask
	task automatic t_dir;
		for (int s = 0; s < 7; s++) begin
			@(posedge CLK);
			PIN_SELECT <= 3'(s);
			tick(1);
			chk("direction", 16'(s != 0), 16'(PIN_DIRECTION));
		end
		$display("direction test done");
	endtask
	task automatic t_src(input logic [5:0] lv);
		logic [6:0] v;
		@(posedge CLK);
		FRAME_READOUT_FLAG <= lv[0];
		ROW_TIME_FLAG <= lv[1];
		EXPOSURE_START <= lv[2];
		EXPOSURE_END <= !lv[2];
		USER_LEVEL_VALUE <= lv[3];
		TIMER_PULSE_SOURCE <= lv[4];
		COUNTER_PULSE_SOURCE <= lv[5];
		@(posedge CLK);
		EXPOSURE_START <= 1'h0;
		EXPOSURE_END <= 1'h0;
		tick(1);
		chk("exposure", 16'(lv[2]), 16'(EXPOSURE_FLAG));
		v = {lv, 1'h0};
		for (int s = 0; s < 7; s++) for (int i = 0; i < 2; i++) begin
			cfg(3'(s % 6 + 1), 3'(s), i[0]);
			tick(3);
			chk("enable", 16'(s != 0), 16'(OUTPUT_PINS_OE[s % 6]));
			if (s != 0) chk("pin", 16'(v[s] ^ i[0]), 16'(OUTPUT_PINS[s % 6]));
		end
		cfg(3'h0, SRC_OFF, 1'h0);
		tick(3);
		chk("refused", 16'h1, 16'(OUTPUT_PINS_OE[0]));
		$display("source test done");
	endtask
	task automatic t_filt;
		@(posedge CLK);
		GLITCH_FILTER_TIME <= 20'h00002;
		u_far.drive(1'h1, 40);
		u_far.drive(1'h0, 150);
		chk("glitch high", 16'h0, 16'(TRIGGER_CLEAN));
		u_far.drive(1'h1, 60);
		chk("early", 16'h0, 16'(TRIGGER_CLEAN));
		u_far.drive(1'h1, 100);
		chk("late", 16'h1, 16'(TRIGGER_CLEAN));
		u_far.drive(1'h0, 40);
		u_far.drive(1'h1, 10);
		chk("glitch low", 16'h1, 16'(TRIGGER_CLEAN));
		@(posedge CLK);
		GLITCH_FILTER_TIME <= 20'h00000;
		u_far.drive(1'h0, 8);
		chk("bypass", 16'h0, 16'(TRIGGER_CLEAN));
		$display("filter test done");
	endtask
	task automatic fire(input logic en);
		@(posedge CLK);
		EVENT_MESSAGE_ENABLE <= en;
		TEST_EVENT_FIRE <= 1'h1;
		@(posedge CLK);
		TEST_EVENT_FIRE <= 1'h0;
		#1;
	endtask
	task automatic t_evt;
		int k;
		int k0;
		fire(1'h0);
		tick(3);
		chk("disabled", 16'h0, 16'(EVENT_VALID));
		lat = 4'h3;
		fire(1'h1);
		chk("valid", 16'h1, 16'(EVENT_VALID));
		chk("id", EVT_ID_TEST, EVENT_ID);
		// Second command while busy must be remembered
		fire(1'h1);
		k = 0;
		while (EVENT_VALID === 1'h1 && k < 50) begin
			tick(1);
			k++;
		end
		chk("held", 16'h1, 16'(k > 2));
		k0 = k;
		while (EVENT_VALID !== 1'h1 && k < 400) begin
			tick(1);
			k++;
		end
		chk("queued", 16'h1, 16'(EVENT_VALID));
		// Hold-off of two microseconds, tick phase leaves at least one full tick
		chk("hold-off", 16'h1, 16'(k - k0 >= TICK_CYCLES));
		$display("event test done");
	endtask
	task automatic give_verdict;
		$display("checks %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		RST = 1'h1;
		{FRAME_READOUT_FLAG, ROW_TIME_FLAG, EXPOSURE_START, EXPOSURE_END, TIMER_PULSE_SOURCE,
			COUNTER_PULSE_SOURCE, CFG_WRITE, OUTPUT_INVERT, USER_LEVEL_VALUE, EVENT_TYPE_SELECT,
			EVENT_MESSAGE_ENABLE, TEST_EVENT_FIRE, PIN_SELECT, OUTPUT_SOURCE_SELECT,
			GLITCH_FILTER_TIME, lat} = '0;
		TEST_ACK_WAIT = 16'h0002;
		repeat (4) @(posedge CLK);
		RST <= 1'h0;
		t_dir;
		t_src(6'h2d);
		t_src(6'h12);
		t_filt;
		t_evt;
		give_verdict;
	end
	// Whole run needs about 700 cycles
	initial begin
		repeat (5000) @(posedge CLK);
		n_fail++;
		give_verdict;
	end
endmodule
`default_nettype wire

//--- design/cdio_debounce.sv
// Glitch filter for the trigger input pin
`default_nettype none
module cdio_debounce
	import cdio_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Filter
	input wire logic tick,
	input wire logic [GLITCH_W-1:0] filter_time,
	input wire logic raw,
	output logic clean
);
	logic last_q;
	logic clean_q;
	logic [GLITCH_W-1:0] cnt_q;
	wire changed = raw != last_q;
	wire bypass = filter_time == GLITCH_RST;
	wire done = cnt_q >= filter_time;

	always_ff @(posedge clk) begin
		if (rst) begin
			last_q <= 1'b0;
			clean_q <= 1'b0;
			cnt_q <= GLITCH_RST;
		end else begin
			last_q <= raw;
			// Restart on any raw change so short pulses never commit
			if (bypass) begin
				clean_q <= raw; // RQ13
				cnt_q <= GLITCH_RST;
			end else if (changed) begin
				cnt_q <= GLITCH_RST; // RQ8
			end else if (raw != clean_q) begin
				if (done)
					clean_q <= raw; // RQ9
				else if (tick)
					cnt_q <= cnt_q + GLITCH_W'(1); // RQ13
			end else begin
				cnt_q <= GLITCH_RST;
			end
		end
	end
	assign clean = clean_q;
endmodule
`default_nettype wire

//--- design/cdio_pkg.sv
// Constants and types shared by the camera digital I/O block
`default_nettype none
package cdio_pkg;
	localparam int CLK_HZ = 50000000;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYCLES = (TICK_NS * (CLK_HZ / 1000000)) / 1000;
	localparam int NUM_OUT = 6;
	localparam int GLITCH_W = 20;
	localparam logic [GLITCH_W-1:0] GLITCH_MAX = 20'hf4240;
	localparam logic [GLITCH_W-1:0] GLITCH_RST = 20'h00000;
	localparam int SRC_W = 3;
	localparam logic [SRC_W-1:0] SRC_OFF = 3'h0;
	localparam logic [SRC_W-1:0] SRC_FRAME = 3'h1;
	localparam logic [SRC_W-1:0] SRC_ROW = 3'h2;
	localparam logic [SRC_W-1:0] SRC_EXPO = 3'h3;
	localparam logic [SRC_W-1:0] SRC_USER = 3'h4;
	localparam logic [SRC_W-1:0] SRC_TIMER = 3'h5;
	localparam logic [SRC_W-1:0] SRC_COUNT = 3'h6;
	localparam int SEL_W = 3;
	localparam logic [SEL_W-1:0] PIN_TRIGGER = 3'h0;
	localparam logic EVT_TEST = 1'h0;
	localparam logic [15:0] EVT_ID_TEST = 16'h4e21;
	typedef enum logic [2:0] {
		CDIO_IDLE = 3'b001,
		CDIO_SEND = 3'b010,
		CDIO_WAIT = 3'b100
	} cdio_evt_state_t;
endpackage
`default_nettype wire

//--- design/cdio_top.sv
// Camera digital I/O: filtered trigger input, six sourced outputs, test event
// Contract
// RQ1 - First control line is input only; selecting it reports input direction.
// RQ2 - Six remaining lines are outputs only, each configured via line selection.
// RQ3 - Inversion true drives complement of the selected source, false drives it unchanged.
// RQ4 - Source off keeps the output disabled with no activity.
// RQ5 - Route frame, row, exposure, user, timer or counter source to each output.
// RQ6 - User source drives low for false and high for true.
// RQ7 - Exposure flag rises at exposure start and falls at exposure end.
// RQ8 - Input change accepted only after persisting the debounce time; shorter pulses dropped.
// RQ9 - Validated change appears delayed by the debounce time.
// RQ10 - Debounce time 0 to 1,000,000 microseconds, default zero.
// RQ11 - Event message sent only while that type's notification enable is on.
// RQ12 - Test-event command creates a test event and, if enabled, a message.
// RQ13 - Debounce is a microsecond tick counter restarted on raw change; zero bypasses.
`default_nettype none
module cdio_top
	import cdio_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Connector
	input wire logic TRIGGER_INPUT_PIN,
	output logic [cdio_pkg::NUM_OUT-1:0] OUTPUT_PINS,
	output logic [cdio_pkg::NUM_OUT-1:0] OUTPUT_PINS_OE,
	// Internal sources
	input wire logic FRAME_READOUT_FLAG,
	input wire logic ROW_TIME_FLAG,
	input wire logic EXPOSURE_START,
	input wire logic EXPOSURE_END,
	input wire logic TIMER_PULSE_SOURCE,
	input wire logic COUNTER_PULSE_SOURCE,
	// Line configuration
	input wire logic [cdio_pkg::SEL_W-1:0] PIN_SELECT,
	input wire logic CFG_WRITE,
	input wire logic [cdio_pkg::SRC_W-1:0] OUTPUT_SOURCE_SELECT,
	input wire logic OUTPUT_INVERT,
	input wire logic USER_LEVEL_VALUE,
	input wire logic [cdio_pkg::GLITCH_W-1:0] GLITCH_FILTER_TIME,
	output logic PIN_DIRECTION,
	// Status
	output logic EXPOSURE_FLAG,
	output logic TRIGGER_CLEAN,
	// Events
	input wire logic EVENT_TYPE_SELECT,
	input wire logic EVENT_MESSAGE_ENABLE,
	input wire logic TEST_EVENT_FIRE,
	input wire logic [15:0] TEST_ACK_WAIT,
	output logic EVENT_VALID,
	output logic [15:0] EVENT_ID,
	input wire logic EVENT_READY
);
	import cdio_pkg::*;

	// Pin synchroniser, first stage read only by the second
	logic trig_s1_q;
	logic trig_s2_q;
	always_ff @(posedge CLK) begin
		if (RST) begin
			trig_s1_q <= 1'b0;
			trig_s2_q <= 1'b0;
		end else begin
			trig_s1_q <= TRIGGER_INPUT_PIN;
			trig_s2_q <= trig_s1_q;
		end
	end

	// Microsecond tick
	logic [7:0] tick_cnt_q;
	wire tick = tick_cnt_q == 8'(TICK_CYCLES - 1);
	always_ff @(posedge CLK) begin
		if (RST)
			tick_cnt_q <= 8'h00;
		else if (tick)
			tick_cnt_q <= 8'h00;
		else
			tick_cnt_q <= tick_cnt_q + 8'h01;
	end

	// Filter time, clamped to the legal range
	logic [GLITCH_W-1:0] glitch_q;
	wire [GLITCH_W-1:0] glitch_d = (GLITCH_FILTER_TIME > GLITCH_MAX) ? GLITCH_MAX
		: GLITCH_FILTER_TIME;
	always_ff @(posedge CLK) begin
		if (RST)
			glitch_q <= GLITCH_RST; // RQ10
		else
			glitch_q <= glitch_d; // RQ10
	end

	logic trig_clean;
	cdio_debounce u_deb (
		.clk(CLK),
		.rst(RST),
		.tick(tick),
		.filter_time(glitch_q),
		.raw(trig_s2_q),
		.clean(trig_clean)
	);
	assign TRIGGER_CLEAN = trig_clean; // RQ9

	// Selection of the trigger pin reports input; any other pin is an output
	assign PIN_DIRECTION = PIN_SELECT != PIN_TRIGGER; // RQ1
	wire [SEL_W-1:0] out_idx = PIN_SELECT - 3'h1;
	wire sel_output = PIN_SELECT != PIN_TRIGGER && PIN_SELECT <= 3'(NUM_OUT);

	// Exposure flag
	logic expo_q;
	always_ff @(posedge CLK) begin
		if (RST)
			expo_q <= 1'b0;
		else if (EXPOSURE_START)
			expo_q <= 1'b1; // RQ7
		else if (EXPOSURE_END)
			expo_q <= 1'b0; // RQ7
	end
	assign EXPOSURE_FLAG = expo_q;

	// Per-line configuration and output drive
	logic [SRC_W-1:0] src_q [NUM_OUT];
	logic [NUM_OUT-1:0] inv_q;
	logic [NUM_OUT-1:0] pin_q;
	logic [NUM_OUT-1:0] oe_q;
	logic user_q;
	always_ff @(posedge CLK) begin
		if (RST)
			user_q <= 1'b0;
		else
			user_q <= USER_LEVEL_VALUE;
	end

	genvar g;
	generate
		for (g = 0; g < NUM_OUT; g++) begin : g_out
			logic level;
			wire wr = CFG_WRITE && sel_output && out_idx == 3'(g);
			always_comb begin
				unique case (src_q[g])
					SRC_FRAME: level = FRAME_READOUT_FLAG; // RQ5
					SRC_ROW: level = ROW_TIME_FLAG;
					SRC_EXPO: level = expo_q;
					SRC_USER: level = user_q; // RQ6
					SRC_TIMER: level = TIMER_PULSE_SOURCE;
					SRC_COUNT: level = COUNTER_PULSE_SOURCE;
					default: level = 1'b0;
				endcase
			end
			always_ff @(posedge CLK) begin
				if (RST) begin
					src_q[g] <= SRC_OFF;
					inv_q[g] <= 1'b0;
				end else if (wr) begin
					src_q[g] <= OUTPUT_SOURCE_SELECT; // RQ2
					inv_q[g] <= OUTPUT_INVERT;
				end
			end
			always_ff @(posedge CLK) begin
				if (RST) begin
					pin_q[g] <= 1'b0;
					oe_q[g] <= 1'b0;
				end else if (src_q[g] == SRC_OFF) begin
					pin_q[g] <= 1'b0; // RQ4
					oe_q[g] <= 1'b0; // RQ4
				end else begin
					pin_q[g] <= level ^ inv_q[g]; // RQ3
					oe_q[g] <= 1'b1;
				end
			end
		end
	endgenerate
	assign OUTPUT_PINS = pin_q;
	assign OUTPUT_PINS_OE = oe_q;

	// Test event: one message per fire from idle, one queued for all fires while busy, then a hold-off of the ack wait
	cdio_evt_state_t st_q;
	logic [15:0] wait_q;
	logic evt_pend_q;
	wire fire_ok = TEST_EVENT_FIRE && EVENT_MESSAGE_ENABLE
		&& EVENT_TYPE_SELECT == EVT_TEST;
	always_ff @(posedge CLK) begin
		if (RST) begin
			st_q <= CDIO_IDLE;
			wait_q <= 16'h0000;
			evt_pend_q <= 1'b0;
		end else begin
			// The first fire during send or wait is kept, not lost; later ones merge with it
			if (fire_ok && st_q != CDIO_IDLE)
				evt_pend_q <= 1'b1; // RQ12
			unique case (st_q)
				CDIO_IDLE: begin
					if (fire_ok || evt_pend_q) begin
						st_q <= CDIO_SEND; // RQ11
						evt_pend_q <= 1'b0;
					end
				end
				CDIO_SEND: begin
					if (EVENT_READY) begin
						st_q <= CDIO_WAIT;
						wait_q <= TEST_ACK_WAIT;
					end
				end
				CDIO_WAIT: begin
					if (wait_q == 16'h0000)
						st_q <= CDIO_IDLE;
					else if (tick)
						wait_q <= wait_q - 16'h0001;
				end
				default: st_q <= CDIO_IDLE;
			endcase
		end
	end
	assign EVENT_VALID = st_q == CDIO_SEND; // RQ12
	assign EVENT_ID = EVT_ID_TEST;
endmodule
`default_nettype wire
